// File: rtl/serial_port_one_config_regs.sv
`timescale 1ns/1ps
module serial_port_one_config_regs
  import serial_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // avalon-mm slave, word addressed by byte address
  input wire logic [9:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // serial port core status
  input wire logic i_transfer_busy,
  input wire logic i_ring_indicate_input,
  // serial port core requests for its own registers
  input wire logic i_port_reg_access,
  input wire logic i_port_reg_extended,
  // controls to the serial port core
  output logic o_port_clock_enable,
  output logic o_port_outputs_default,
  output logic o_port_output_enable,
  output logic o_port_reg_access_grant,
  output logic o_ring_wake_enable,
  output logic [15:0] o_base_address,
  output logic [7:0] o_irq_number,
  output logic [7:0] o_irq_type,
  output port_ctrl_type o_port_ctrl
);

  logic [7:0] activate_reg;
  logic [7:0] base_high_reg;
  logic [7:0] base_low_reg;
  logic [7:0] irq_number_reg;
  logic [7:0] irq_type_reg;
  logic [7:0] device_config_reg;
  logic [31:0] readdata_reg;
  bus_state_type bus_state_reg;
  bus_state_type bus_state_next;
  logic busy_sync;
  logic [7:0] index;
  logic word_aligned;
  logic write_take;
  logic lane_zero;
  logic [7:0] read_value;
  logic device_active;

  sync_two_flop u_busy_sync (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(i_transfer_busy),
    .o_sync(busy_sync)
  );

  // merge masked write bits into a register value
  function automatic logic [7:0] masked_write(input logic [7:0] old_value,
                                              input logic [7:0] new_value,
                                              input logic [7:0] mask);
    masked_write = (old_value & ~mask) | (new_value & mask);
  endfunction

  assign index = i_avs_address[9:2];
  assign word_aligned = (i_avs_address[1:0] == 2'h0);
  // writes complete with no wait; reads take one answer cycle
  assign write_take = i_avs_write && word_aligned;
  assign lane_zero = i_avs_byteenable[0];
  assign device_active = activate_reg[BIT_ACTIVE];

  always_comb begin
    bus_state_next = BUS_IDLE;
    case (bus_state_reg)
      BUS_IDLE: begin
        if (i_avs_read) begin
          bus_state_next = BUS_ANSWER;
        end
      end
      BUS_ANSWER: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // read is held until readdata is ready in the answer cycle
  assign o_avs_waitrequest = i_avs_read && (bus_state_reg != BUS_ANSWER);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      activate_reg <= RST_PORT_ACTIVATE;
    end else if (write_take && lane_zero && index == IDX_PORT_ACTIVATE) begin
      activate_reg <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      base_high_reg <= RST_BASE_HIGH;
      base_low_reg <= RST_BASE_LOW;
    end else if (write_take && lane_zero) begin
      if (index == IDX_BASE_HIGH) begin
        base_high_reg <= masked_write(base_high_reg, i_avs_writedata[7:0], MASK_BASE_HIGH);
      end
      if (index == IDX_BASE_LOW) begin
        base_low_reg <= masked_write(base_low_reg, i_avs_writedata[7:0], MASK_BASE_LOW);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_number_reg <= RST_IRQ_NUMBER;
      irq_type_reg <= RST_IRQ_TYPE;
    end else if (write_take && lane_zero) begin
      if (index == IDX_IRQ_NUMBER) begin
        irq_number_reg <= i_avs_writedata[7:0];
      end
      if (index == IDX_IRQ_TYPE) begin
        irq_type_reg <= masked_write(irq_type_reg, i_avs_writedata[7:0], MASK_IRQ_TYPE);
      end
    end
  end

  // busy bit is not stored; it is merged on read
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      device_config_reg <= RST_DEVICE_CONFIG;
    end else if (write_take && lane_zero && index == IDX_DEVICE_CONFIG) begin
      device_config_reg <= masked_write(device_config_reg, i_avs_writedata[7:0],
                                        MASK_DEVICE_CONFIG);
    end
  end

  always_comb begin
    read_value = 8'h00;
    case (index)
      IDX_PORT_ACTIVATE: read_value = activate_reg;
      IDX_BASE_HIGH: read_value = base_high_reg & MASK_BASE_HIGH;
      IDX_BASE_LOW: read_value = base_low_reg & MASK_BASE_LOW;
      IDX_IRQ_NUMBER: read_value = irq_number_reg;
      IDX_IRQ_TYPE: read_value = irq_type_reg;
      IDX_DMA_REPORT_ZERO: read_value = DMA_REPORT_VALUE;
      IDX_DMA_REPORT_ONE: read_value = DMA_REPORT_VALUE;
      IDX_DEVICE_CONFIG: begin
        read_value = device_config_reg & MASK_DEVICE_CONFIG;
        read_value[BIT_BUSY] = busy_sync;
      end
      default: read_value = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      readdata_reg <= 32'h0000_0000;
    end else if (i_avs_read && bus_state_reg == BUS_IDLE) begin
      readdata_reg <= word_aligned ? {24'h00_0000, read_value} : 32'h0000_0000;
    end
  end

  assign o_avs_readdata = readdata_reg;

  // port-side controls follow the configuration
  assign o_port_clock_enable = device_active && device_config_reg[BIT_POWER_MODE];
  assign o_port_outputs_default = !o_port_clock_enable;
  assign o_port_output_enable = device_active || !device_config_reg[BIT_TRISTATE];
  // low power leaves access open; extended bank needs bank enable
  assign o_port_reg_access_grant = i_port_reg_access && device_active &&
    (!i_port_reg_extended || device_config_reg[BIT_BANK_ENABLE]);
  // ring indicate wake stays live in low power
  assign o_ring_wake_enable = device_active && i_ring_indicate_input;
  assign o_base_address = {base_high_reg & MASK_BASE_HIGH, base_low_reg & MASK_BASE_LOW};
  assign o_irq_number = irq_number_reg;
  assign o_irq_type = irq_type_reg;
  assign o_port_ctrl = '{bank_enable: device_config_reg[BIT_BANK_ENABLE],
                         power_normal: device_config_reg[BIT_POWER_MODE],
                         tristate_enable: device_config_reg[BIT_TRISTATE],
                         active: device_active};

  property p_activate_reset;
    @(posedge i_sys_clk) $rose(i_reset_n) |-> activate_reg == RST_PORT_ACTIVATE;
  endproperty
  a_activate_reset: assert property (p_activate_reset) else $error("activate reset");

  property p_base_high_ro;
    @(posedge i_sys_clk) disable iff (!i_reset_n) base_high_reg[7:3] == 5'h00;
  endproperty
  a_base_high_ro: assert property (p_base_high_ro) else $error("base high bits set");

  property p_base_low_ro;
    @(posedge i_sys_clk) disable iff (!i_reset_n) o_base_address[2:0] == 3'h0;
  endproperty
  a_base_low_ro: assert property (p_base_low_ro) else $error("base low not aligned");

  property p_irq_number_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (write_take && lane_zero && index == IDX_IRQ_NUMBER) |=>
        o_irq_number == $past(i_avs_writedata[7:0]);
  endproperty
  a_irq_number_write: assert property (p_irq_number_write) else $error("irq number");

  property p_irq_type_mask;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      o_irq_type[7:2] == 6'h00 && o_irq_type[0] == 1'b1;
  endproperty
  a_irq_type_mask: assert property (p_irq_type_mask) else $error("irq type ro bits");

  property p_dma_report;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_avs_read && !o_avs_waitrequest && (index == IDX_DMA_REPORT_ZERO ||
        index == IDX_DMA_REPORT_ONE) && word_aligned) |-> o_avs_readdata == 32'h0000_0004;
  endproperty
  a_dma_report: assert property (p_dma_report) else $error("dma report");

  property p_config_reserved;
    @(posedge i_sys_clk) disable iff (!i_reset_n) device_config_reg[6:2] == 5'h00;
  endproperty
  a_config_reserved: assert property (p_config_reserved) else $error("reserved bits");

  property p_low_power;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (device_active && !device_config_reg[BIT_POWER_MODE]) |->
        !o_port_clock_enable && o_port_outputs_default;
  endproperty
  a_low_power: assert property (p_low_power) else $error("clock not gated");

  property p_tristate;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (!device_active && device_config_reg[BIT_TRISTATE]) |-> !o_port_output_enable;
  endproperty
  a_tristate: assert property (p_tristate) else $error("outputs not released");

  property p_bank_block;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_port_reg_extended && !device_config_reg[BIT_BANK_ENABLE]) |-> !o_port_reg_access_grant;
  endproperty
  a_bank_block: assert property (p_bank_block) else $error("extended access");

  property p_config_reset;
    @(posedge i_sys_clk) $rose(i_reset_n) |-> device_config_reg == RST_DEVICE_CONFIG;
  endproperty
  a_config_reset: assert property (p_config_reset) else $error("config reset");

  property p_bank_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (write_take && lane_zero && index == IDX_DEVICE_CONFIG) |=>
        o_port_ctrl.bank_enable == $past(i_avs_writedata[BIT_BANK_ENABLE]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("bank enable write");

  // busy is whatever the synchroniser held when the read was captured
  property p_busy_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_avs_read && !o_avs_waitrequest && word_aligned && index == IDX_DEVICE_CONFIG) |->
        o_avs_readdata[BIT_BUSY] == $past(busy_sync);
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy bit");

  property p_clock_run;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (device_active && device_config_reg[BIT_POWER_MODE]) |->
        o_port_clock_enable && !o_port_outputs_default;
  endproperty
  a_clock_run: assert property (p_clock_run) else $error("clock not running");

  property p_ring_wake;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (device_active && i_ring_indicate_input) |-> o_ring_wake_enable;
  endproperty
  a_ring_wake: assert property (p_ring_wake) else $error("ring wake lost");

  property p_access_open;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_port_reg_access && device_active && !i_port_reg_extended) |->
        o_port_reg_access_grant;
  endproperty
  a_access_open: assert property (p_access_open) else $error("access blocked");

  property p_inactive_block;
    @(posedge i_sys_clk) disable iff (!i_reset_n) !device_active |-> !o_port_reg_access_grant;
  endproperty
  a_inactive_block: assert property (p_inactive_block) else $error("inactive access");

endmodule

// File: rtl/serial_cfg_pkg.sv
package serial_cfg_pkg;

  // register indices, one aligned 32-bit word each
  localparam logic [7:0] IDX_PORT_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_NUMBER = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
  localparam logic [7:0] IDX_DMA_REPORT_ZERO = 8'h74;
  localparam logic [7:0] IDX_DMA_REPORT_ONE = 8'h75;
  localparam logic [7:0] IDX_DEVICE_CONFIG = 8'hF0;

  // reset values
  localparam logic [7:0] RST_PORT_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_BASE_HIGH = 8'h03;
  localparam logic [7:0] RST_BASE_LOW = 8'hF8;
  localparam logic [7:0] RST_IRQ_NUMBER = 8'h04;
  localparam logic [7:0] RST_IRQ_TYPE = 8'h03;
  localparam logic [7:0] DMA_REPORT_VALUE = 8'h04;
  localparam logic [7:0] RST_DEVICE_CONFIG = 8'h02;

  // writable masks
  localparam logic [7:0] MASK_BASE_HIGH = 8'h07;
  localparam logic [7:0] MASK_BASE_LOW = 8'hF8;
  localparam logic [7:0] MASK_IRQ_TYPE = 8'h02;
  localparam logic [7:0] MASK_DEVICE_CONFIG = 8'h83;

  // device config and port activate field positions
  localparam int BIT_BANK_ENABLE = 7;
  localparam int BIT_BUSY = 2;
  localparam int BIT_POWER_MODE = 1;
  localparam int BIT_TRISTATE = 0;
  localparam int BIT_ACTIVE = 0;

  // read answer latency in cycles after the request is seen
  localparam int READ_WAIT_CYCLES = 1;

  typedef struct packed {
    logic bank_enable;
    logic power_normal;
    logic tristate_enable;
    logic active;
  } port_ctrl_type;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_type;

endpackage

// File: rtl/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop
  import serial_cfg_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // asynchronous level in, synchronised level out
  input wire logic i_async,
  output logic o_sync
);
  logic stage_one_reg;
  logic stage_two_reg;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stage_one_reg <= 1'b0;
      stage_two_reg <= 1'b0;
    end else begin
      stage_one_reg <= i_async;
      stage_two_reg <= stage_one_reg;
    end
  end

  assign o_sync = stage_two_reg;
endmodule

// File: testbench/tb_serial_port_one_config_regs.sv
`timescale 1ns/1ps
module tb_serial_port_one_config_regs;
  import serial_cfg_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [9:0] i_avs_address = 10'h000;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [3:0] i_avs_byteenable = 4'hF;
  logic i_transfer_busy = 1'b0;
  logic i_ring_indicate_input = 1'b0;
  logic i_port_reg_access = 1'b0;
  logic i_port_reg_extended = 1'b0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest, o_port_clock_enable, o_port_outputs_default;
  logic o_port_output_enable, o_port_reg_access_grant, o_ring_wake_enable;
  logic [15:0] o_base_address;
  logic [7:0] o_irq_number, o_irq_type;
  port_ctrl_type o_port_ctrl;
  int n_fail = 0;
  int tests_run = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h00011808;
  logic [7:0] idx_t[8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0};
  logic [7:0] msk_t[8] = '{8'hFF, 8'h07, 8'hF8, 8'hFF, 8'h02, 8'h00, 8'h00, 8'h83};
  logic [7:0] rst_t[8] = '{8'h00, 8'h03, 8'hF8, 8'h04, 8'h03, 8'h04, 8'h04, 8'h02};
  logic [7:0] exp_v[8];
  logic [7:0] v;

  serial_port_one_config_regs dut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_transfer_busy(i_transfer_busy),
    .i_ring_indicate_input(i_ring_indicate_input), .i_port_reg_access(i_port_reg_access),
    .i_port_reg_extended(i_port_reg_extended), .o_port_clock_enable(o_port_clock_enable),
    .o_port_outputs_default(o_port_outputs_default),
    .o_port_output_enable(o_port_output_enable),
    .o_port_reg_access_grant(o_port_reg_access_grant),
    .o_ring_wake_enable(o_ring_wake_enable), .o_base_address(o_base_address),
    .o_irq_number(o_irq_number), .o_irq_type(o_irq_type), .o_port_ctrl(o_port_ctrl)
  );

  initial begin
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic co(input logic s, input logic e);
    check({31'h0, s}, {31'h0, e});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // no cycle count assumed: wait for the slave, bounded only by a limit
  task automatic wait_ack;
    int n;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      $display("Error at %0t: bus answer missing", $time);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
                    input logic [1:0] lo = 2'b00);
    @(posedge i_sys_clk);
    i_avs_write <= 1'b1;
    i_avs_address <= {idx, lo};
    i_avs_writedata <= {24'h000000, d};
    i_avs_byteenable <= be;
    wait_ack();
    i_avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] e, input logic [1:0] lo = 2'b00);
    @(posedge i_sys_clk);
    i_avs_read <= 1'b1;
    i_avs_address <= {idx, lo};
    exp_q.push_back({24'h000000, e});
    wait_ack();
    i_avs_read <= 1'b0;
  endtask

  task automatic settle;
    @(posedge i_sys_clk);
    #1;
  endtask

  // data is taken only at the edge where the slave stops waiting
  always @(posedge i_sys_clk) begin
    if (i_avs_read === 1'b1 && o_avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("Error at %0t: unexpected read data", $time);
      end else check(o_avs_readdata, exp_q.pop_front());
    end
  end

  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    #1;
    check({16'h0, o_base_address}, 32'h000003F8);
    co(o_port_clock_enable, 1'b0);
    co(o_port_output_enable, 1'b1);
    for (int i = 0; i < 8; i++) rd(idx_t[i], rst_t[i]);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = next_rnd(seed);
      v = seed[7:0];
      exp_v[i] = (v & msk_t[i]) | (rst_t[i] & ~msk_t[i]);
      wr(idx_t[i], v, 4'hF);
      rd(idx_t[i], exp_v[i]);
    end
    settle();
    check({16'h0, o_base_address}, {16'h0, exp_v[1], exp_v[2]});
    check({24'h0, o_irq_number}, {24'h0, exp_v[3]});
    check({24'h0, o_irq_type}, {24'h0, exp_v[4]});
    wr(8'h31, 8'hA5, 4'hF);
    rd(8'h31, 8'h00);
    wr(8'h70, ~exp_v[3], 4'hE);
    rd(8'h70, exp_v[3]);
    // off-word addresses are refused in both directions
    wr(8'h70, ~exp_v[3], 4'hF, 2'b01);
    rd(8'h70, exp_v[3]);
    rd(8'h70, 8'h00, 2'b10);
    $display("read write masks done");
    i_transfer_busy <= 1'b1;
    repeat (4) settle();
    rd(8'hF0, exp_v[7] | 8'h04);
    i_transfer_busy <= 1'b0;
    repeat (4) settle();
    rd(8'hF0, exp_v[7]);
    $display("busy flag done");
    wr(8'h30, 8'h01, 4'hF);
    wr(8'hF0, 8'h02, 4'hF);
    i_ring_indicate_input <= 1'b1;
    i_port_reg_access <= 1'b1;
    settle();
    co(o_port_clock_enable, 1'b1);
    co(o_port_outputs_default, 1'b0);
    co(o_port_ctrl.active, 1'b1);
    co(o_port_ctrl.power_normal, 1'b1);
    wr(8'hF0, 8'h00, 4'hF);
    settle();
    co(o_port_clock_enable, 1'b0);
    co(o_port_outputs_default, 1'b1);
    co(o_port_ctrl.power_normal, 1'b0);
    co(o_ring_wake_enable, 1'b1);
    co(o_port_reg_access_grant, 1'b1);
    rd(8'h70, exp_v[3]);
    $display("power mode done");
    i_port_reg_extended <= 1'b1;
    settle();
    co(o_port_reg_access_grant, 1'b0);
    wr(8'hF0, 8'h80, 4'hF);
    settle();
    co(o_port_reg_access_grant, 1'b1);
    co(o_port_ctrl.bank_enable, 1'b1);
    wr(8'h30, 8'h00, 4'hF);
    settle();
    co(o_port_reg_access_grant, 1'b0);
    co(o_port_output_enable, 1'b1);
    wr(8'hF0, 8'h81, 4'hF);
    settle();
    co(o_port_output_enable, 1'b0);
    co(o_port_ctrl.tristate_enable, 1'b1);
    wr(8'h30, 8'h01, 4'hF);
    settle();
    co(o_port_output_enable, 1'b1);
    $display("bank and output control done");
    // reset again with the port active and configured
    @(posedge i_sys_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rd(8'h30, 8'h00);
    rd(8'hF0, 8'h02);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
